// ---- gtu_pkg.sv ----
// Package for the three-timer general purpose unit: offsets, fields, modes, timing
package gtu_pkg;

  // ==========================================================================
  // Register offsets (byte address, one 32-bit word = 4 bytes apart)
  // ==========================================================================
  localparam logic [7:0] OFS_CORE_CTRL  = 8'h00;  // Core timer control
  localparam logic [7:0] OFS_AUXA_CTRL  = 8'h04;  // Aux timer A control
  localparam logic [7:0] OFS_AUXB_CTRL  = 8'h08;  // Aux timer B control
  localparam logic [7:0] OFS_CORE_CNT   = 8'h0c;  // Core timer count
  localparam logic [7:0] OFS_AUXA_CNT   = 8'h10;  // Aux timer A count
  localparam logic [7:0] OFS_AUXB_CNT   = 8'h14;  // Aux timer B count
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h18;  // Sticky request flags
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;  // Request mask
  localparam logic [7:0] OFS_PRESCALE   = 8'h20;  // Prescaler exponent

  // ==========================================================================
  // Control register field positions
  // ==========================================================================
  localparam int CTL_MODE_LSB = 0;   // [2:0] mode
  localparam int CTL_RUN_BIT  = 3;   // Run enable
  localparam int CTL_DOWN_BIT = 4;   // Software direction, 1 = down
  localparam int CTL_EXTD_BIT = 5;   // External direction pin enable
  localparam int CTL_GPOL_BIT = 6;   // Gate / edge polarity, 1 = active high / rising
  localparam int CTL_CLKL_BIT = 7;   // Aux: clock from core toggle latch
  localparam int CTL_TRG_LSB  = 8;   // [9:8] aux reload trigger select
  localparam int CTL_WIDTH    = 10;

  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h000;
  localparam logic [15:0]          CNT_RESET = 16'h0000;
  localparam logic [2:0]           PRE_RESET = 3'h0;

  // ==========================================================================
  // Modes and reload triggers
  // ==========================================================================
  typedef enum logic [2:0] {
    GTU_MODE_TIMER   = 3'b000,
    GTU_MODE_GATED   = 3'b001,
    GTU_MODE_COUNTER = 3'b010,
    GTU_MODE_INCR    = 3'b011,
    GTU_MODE_CAPTURE = 3'b100,
    GTU_MODE_RELOAD  = 3'b101
  } gtu_mode_t;

  typedef enum logic [1:0] {
    GTU_TRG_PIN  = 2'b00,  // Input pin edge
    GTU_TRG_RISE = 2'b01,  // Toggle latch low-to-high
    GTU_TRG_FALL = 2'b10,  // Toggle latch high-to-low
    GTU_TRG_ANY  = 2'b11   // Any toggle latch change
  } gtu_trg_t;

  // Timing: 8 CPU clocks per finest count step (16 half-clock states)
  localparam int MACHINE_CLKS  = 2;               // One machine cycle in CPU clocks
  localparam int BASE_DIV_CLKS = 4 * MACHINE_CLKS; // Finest resolution in clocks
  localparam int PRE_MAX       = 7;               // Largest prescaler exponent

  // Per-timer pin group, carried together
  typedef struct packed {
    logic in_pin;   // Gate, clock, capture trigger or sensor A
    logic dir_pin;  // External direction or sensor B
  } gtu_pins_t;

endpackage

// ---- gtu_top.sv ----
// Three-timer general purpose unit: core timer plus two auxiliary timers
`timescale 1ns/10ps

// Notes on behaviour
// - Three timers, each with 16-bit count
// - Timers run alone or chain via latch
// - Modes: timer, gated, counter, incremental
// - Timer mode counts prescaled CPU clock
// - Counter mode counts input pin edges
// - Gated mode counts while gate active
// - Finest resolution is eight CPU clocks
// - Machine cycle is two CPU clocks
// - Direction by software or external pin
// - Incremental mode decodes quadrature sensor pins
// - Core latch toggles on overflow/underflow
// - Core latch can clock aux timers
// - Aux capture/reload modes stop its counting
// - Capture copies core count on pin
// - Reload loads core from aux on trigger
module gtu_top #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire gtu_pkg::gtu_pins_t [2:0] timer_pins,
  output logic                  core_toggle_latch,
  output logic                  irq
);

  // ==========================================================================
  // Reset release and pin synchronisers
  // ==========================================================================
  logic       rst_s1_ff;          // First reset stage
  logic       rst_n_ff;           // Released reset used everywhere
  logic [5:0] pin_s1_ff;          // First synchroniser stage, read only by stage two
  logic [5:0] pin_s2_ff;          // Synchronised pins
  logic [5:0] pin_d_ff;           // Delayed copy for edge detection

  // Reset is asserted at once and released after two edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Pins are asynchronous to clk_sys, so two flops before any use
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      pin_d_ff  <= 6'h00;
    end else begin
      pin_s1_ff <= timer_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [gtu_pkg::CTL_WIDTH-1:0] ctl_ff [3];   // 0 core, 1 aux A, 2 aux B
  logic [CNT_W-1:0]              cnt_ff [3];   // Count values
  logic [2:0]                    stat_ff;      // Sticky request flags
  logic [2:0]                    mask_ff;      // Request mask
  logic [2:0]                    pre_ff;       // Prescaler exponent
  logic [10:0]                   pre_cnt_ff;   // Free running prescaler
  logic                          tick_ff;      // One-cycle prescaled tick
  logic                          otl_d_ff;     // Previous toggle latch state

  // Decode of a control word's mode field, used for every timer
  function automatic gtu_pkg::gtu_mode_t mode_of(input logic [gtu_pkg::CTL_WIDTH-1:0] c);
    return gtu_pkg::gtu_mode_t'(c[gtu_pkg::CTL_MODE_LSB +: 3]);
  endfunction

  // Write decode of a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return reg_wr && (a == ofs);
  endfunction

  // ==========================================================================
  // Prescaler: base step of eight clocks, then 2**pre_ff further
  // ==========================================================================
  logic [10:0] pre_top;
  assign pre_top = 11'((gtu_pkg::BASE_DIV_CLKS << pre_ff) - 1);

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pre_cnt_ff <= 11'h000;
      tick_ff    <= 1'b0;
    end else if (pre_cnt_ff >= pre_top) begin
      pre_cnt_ff <= 11'h000;
      tick_ff    <= 1'b1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 11'h001;
      tick_ff    <= 1'b0;
    end
  end

  // ==========================================================================
  // Per-timer step, direction and wrap decode
  // ==========================================================================
  logic [2:0] step;       // Count this cycle
  logic [2:0] down;       // Direction of the step
  logic [2:0] wrap;       // Overflow or underflow this cycle
  logic [2:0] pin_edge;   // Active edge on input pin
  logic       otl_rise;
  logic       otl_fall;

  assign otl_rise = core_toggle_latch & ~otl_d_ff;
  assign otl_fall = ~core_toggle_latch & otl_d_ff;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      logic in_s, in_d, dir_s, dir_d, pol, qa_chg, qb_chg;
      assign in_s  = pin_s2_ff[2*g+1];
      assign in_d  = pin_d_ff[2*g+1];
      assign dir_s = pin_s2_ff[2*g];
      assign dir_d = pin_d_ff[2*g];
      assign pol   = ctl_ff[g][gtu_pkg::CTL_GPOL_BIT];
      assign qa_chg = in_s ^ in_d;
      assign qb_chg = dir_s ^ dir_d;
      // Polarity picks rising or falling edge
      assign pin_edge[g] = pol ? (in_s & ~in_d) : (~in_s & in_d);

      always_comb begin
        step[g] = 1'b0;
        // Software direction, optionally inverted by the external pin
        down[g] = ctl_ff[g][gtu_pkg::CTL_DOWN_BIT] ^
                  (ctl_ff[g][gtu_pkg::CTL_EXTD_BIT] & dir_s);
        if (ctl_ff[g][gtu_pkg::CTL_RUN_BIT]) begin
          case (mode_of(ctl_ff[g]))
            gtu_pkg::GTU_MODE_TIMER: begin
              // Aux timers may take the core latch as clock instead
              if (g != 0 && ctl_ff[g][gtu_pkg::CTL_CLKL_BIT])
                step[g] = otl_rise | otl_fall;
              else
                step[g] = tick_ff;
            end
            gtu_pkg::GTU_MODE_GATED:   step[g] = tick_ff & (in_s == pol);
            gtu_pkg::GTU_MODE_COUNTER: step[g] = pin_edge[g];
            gtu_pkg::GTU_MODE_INCR: begin
              // Any sensor edge counts; direction from phase relation
              step[g] = qa_chg | qb_chg;
              down[g] = qa_chg ? (in_s == dir_s) : (in_s != dir_s);
            end
            default: step[g] = 1'b0;   // Capture/reload: stopped
          endcase
        end
      end

      assign wrap[g] = step[g] &
        (down[g] ? (cnt_ff[g] == '0) : (cnt_ff[g] == {CNT_W{1'b1}}));
    end
  endgenerate

  // ==========================================================================
  // Aux capture/reload triggers
  // ==========================================================================
  logic [2:1] cap_ev;   // Capture into aux
  logic [2:1] rld_ev;   // Reload core from aux

  always_comb begin
    cap_ev = 2'b00;
    rld_ev = 2'b00;
    for (int i = 1; i < 3; i++) begin
      if (mode_of(ctl_ff[i]) == gtu_pkg::GTU_MODE_CAPTURE)
        cap_ev[i] = pin_edge[i];
      if (mode_of(ctl_ff[i]) == gtu_pkg::GTU_MODE_RELOAD) begin
        case (gtu_pkg::gtu_trg_t'(ctl_ff[i][gtu_pkg::CTL_TRG_LSB +: 2]))
          gtu_pkg::GTU_TRG_PIN:  rld_ev[i] = pin_edge[i];
          gtu_pkg::GTU_TRG_RISE: rld_ev[i] = otl_rise;
          gtu_pkg::GTU_TRG_FALL: rld_ev[i] = otl_fall;
          gtu_pkg::GTU_TRG_ANY:  rld_ev[i] = otl_rise | otl_fall;
          default:               rld_ev[i] = 1'b0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Control and prescaler registers
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < 3; i++)
        ctl_ff[i] <= gtu_pkg::CTL_RESET;
      pre_ff  <= gtu_pkg::PRE_RESET;
      mask_ff <= 3'h0;
    end else begin
      if (hit(reg_addr, gtu_pkg::OFS_CORE_CTRL))
        ctl_ff[0] <= reg_wdata[gtu_pkg::CTL_WIDTH-1:0];
      if (hit(reg_addr, gtu_pkg::OFS_AUXA_CTRL))
        ctl_ff[1] <= reg_wdata[gtu_pkg::CTL_WIDTH-1:0];
      if (hit(reg_addr, gtu_pkg::OFS_AUXB_CTRL))
        ctl_ff[2] <= reg_wdata[gtu_pkg::CTL_WIDTH-1:0];
      if (hit(reg_addr, gtu_pkg::OFS_PRESCALE))
        pre_ff <= reg_wdata[2:0];
      if (hit(reg_addr, gtu_pkg::OFS_IRQ_MASK))
        mask_ff <= reg_wdata[2:0];
    end
  end

  // ==========================================================================
  // Count registers: software write wins over hardware update
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < 3; i++)
        cnt_ff[i] <= gtu_pkg::CNT_RESET;
    end else begin
      // Core: reload beats its own step; aux B reload wins over aux A
      if (hit(reg_addr, gtu_pkg::OFS_CORE_CNT))
        cnt_ff[0] <= reg_wdata[CNT_W-1:0];
      else if (rld_ev[2])
        cnt_ff[0] <= cnt_ff[2];
      else if (rld_ev[1])
        cnt_ff[0] <= cnt_ff[1];
      else if (step[0])
        cnt_ff[0] <= down[0] ? cnt_ff[0] - 1'b1 : cnt_ff[0] + 1'b1;
      for (int i = 1; i < 3; i++) begin
        if (hit(reg_addr, i == 1 ? gtu_pkg::OFS_AUXA_CNT : gtu_pkg::OFS_AUXB_CNT))
          cnt_ff[i] <= reg_wdata[CNT_W-1:0];
        else if (cap_ev[i])
          cnt_ff[i] <= cnt_ff[0];
        else if (step[i])
          cnt_ff[i] <= down[i] ? cnt_ff[i] - 1'b1 : cnt_ff[i] + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Core toggle latch
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      core_toggle_latch <= 1'b0;
      otl_d_ff          <= 1'b0;
    end else begin
      otl_d_ff <= core_toggle_latch;
      if (wrap[0])
        core_toggle_latch <= ~core_toggle_latch;
    end
  end

  // ==========================================================================
  // Request flags: set beats write-one-to-clear
  // ==========================================================================
  logic [2:0] set_ev;
  assign set_ev = wrap | {cap_ev[2] | rld_ev[2], cap_ev[1] | rld_ev[1], 1'b0};

  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stat_ff <= 3'h0;
      irq     <= 1'b0;
    end else begin
      if (hit(reg_addr, gtu_pkg::OFS_IRQ_STAT))
        stat_ff <= (stat_ff & ~reg_wdata[2:0]) | set_ev;
      else
        stat_ff <= stat_ff | set_ev;
      irq <= |(stat_ff & mask_ff);
    end
  end

  // ==========================================================================
  // Read port: data in the cycle after the strobe, zero when unmapped
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        gtu_pkg::OFS_CORE_CTRL: reg_rdata <= 32'(ctl_ff[0]);
        gtu_pkg::OFS_AUXA_CTRL: reg_rdata <= 32'(ctl_ff[1]);
        gtu_pkg::OFS_AUXB_CTRL: reg_rdata <= 32'(ctl_ff[2]);
        gtu_pkg::OFS_CORE_CNT:  reg_rdata <= 32'(cnt_ff[0]);
        gtu_pkg::OFS_AUXA_CNT:  reg_rdata <= 32'(cnt_ff[1]);
        gtu_pkg::OFS_AUXB_CNT:  reg_rdata <= 32'(cnt_ff[2]);
        gtu_pkg::OFS_IRQ_STAT:  reg_rdata <= 32'(stat_ff);
        gtu_pkg::OFS_IRQ_MASK:  reg_rdata <= 32'(mask_ff);
        gtu_pkg::OFS_PRESCALE:  reg_rdata <= 32'(pre_ff);
        default:                reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_latch_toggles: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    wrap[0] |=> core_toggle_latch != $past(core_toggle_latch))
    else $error("Toggle latch missed a core wrap");

  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    !wrap[0] |=> $stable(core_toggle_latch))
    else $error("Toggle latch changed without wrap");

  a_capture_copy: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    cap_ev[1] && !reg_wr |=> cnt_ff[1] == $past(cnt_ff[0]))
    else $error("Capture did not copy core count");

  // Aux A stays parked between capture edges
  a_capture_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    mode_of(ctl_ff[1]) == gtu_pkg::GTU_MODE_CAPTURE && !cap_ev[1] && !reg_wr
    |=> $stable(cnt_ff[1]))
    else $error("Aux timer A moved while in capture");

  a_reload_load: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    rld_ev[2] && !reg_wr |=> cnt_ff[0] == $past(cnt_ff[2]))
    else $error("Reload did not load core");

  a_aux_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    mode_of(ctl_ff[2]) == gtu_pkg::GTU_MODE_RELOAD && !reg_wr
    |=> $stable(cnt_ff[2]))
    else $error("Aux timer B counted while in reload");

  a_wrap_flag: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    wrap[0] |=> stat_ff[0] ##1 (irq || !$past(mask_ff[0])))
    else $error("Wrap did not raise request");

  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    tick_ff && !reg_wr |=> !tick_ff [*7])
    else $error("Prescaled tick faster than eight clocks");

  a_timer_step: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    step[0] && !down[0] && !reg_wr && rld_ev == 2'b00
    |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001)
    else $error("Core timer failed to count up");

  a_timer_down: assert property (@(posedge clk_sys) disable iff (!rst_n_ff)
    step[0] && down[0] && !reg_wr && rld_ev == 2'b00
    |=> cnt_ff[0] == $past(cnt_ff[0]) - 16'h0001)
    else $error("Core timer failed to count down");

endmodule

// ---- gtu_pin_model.sv ----
// Far-side model of the timer pins: gate, event and quadrature sensor levels
`timescale 1ns/10ps
module gtu_pin_model (
  input  wire logic                clk_sys,
  input  wire logic [2:0]          in_lvl,
  input  wire logic [2:0]          dir_lvl,
  input  wire logic                quad_en,
  input  wire logic                quad_step,
  input  wire logic                quad_back,
  output gtu_pkg::gtu_pins_t [2:0] timer_pins
);
  // ==========================================================================
  // Sensor position, one gray step per request
  // ==========================================================================
  logic [1:0] phase_ff = 2'h0;  // Position modulo four

  // Steps land just after the edge, so pins never move on the sampling edge
  always @(posedge clk_sys) begin
    if (quad_step) begin
      phase_ff <= quad_back ? phase_ff - 2'h1 : phase_ff + 2'h1;
    end
  end

  // ==========================================================================
  // Pin levels
  // ==========================================================================
  // Sensor A leads B when moving forward; plain levels otherwise
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      timer_pins[g].in_pin  = in_lvl[g];
      timer_pins[g].dir_pin = dir_lvl[g];
    end
    if (quad_en) begin
      timer_pins[0].in_pin  = phase_ff[1] ^ phase_ff[0];
      timer_pins[0].dir_pin = phase_ff[1];
    end
  end
endmodule

// ---- tb_three_timer_general_purpose_unit.sv ----
// Self-checking testbench for the three-timer unit
`timescale 1ns/10ps
module tb_three_timer_general_purpose_unit;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                     clk_sys   = 1'b0;
  logic                     nrst      = 1'b0;   // Held low for 16 cycles
  logic [7:0]               reg_addr  = 8'h00;
  logic [31:0]              reg_wdata = 32'h0;
  logic                     reg_wr    = 1'b0;
  logic                     reg_rd    = 1'b0;
  logic [31:0]              reg_rdata;
  gtu_pkg::gtu_pins_t [2:0] timer_pins;
  logic                     core_toggle_latch;
  logic                     irq;
  logic [2:0]               in_lvl    = 3'h0;   // Gate and event levels
  logic [2:0]               dir_lvl   = 3'h0;   // Direction pin levels
  logic                     quad_en   = 1'b0;   // Sensor drives core pins
  logic                     quad_step = 1'b0;
  logic                     quad_back = 1'b0;
  int                       failures  = 0;
  int                       compares  = 0;
  logic [31:0]              v0;
  logic [31:0]              v1;
  logic [7:0]               ra;
  logic                     l0;
  logic                     hit;
  int                       k;
  // Control field helpers, bits [9:3]
  localparam logic [6:0] RUN = 7'h01;
  localparam logic [6:0] DN  = 7'h02;
  localparam logic [6:0] EXD = 7'h04;
  localparam logic [6:0] POL = 7'h08;
  localparam logic [6:0] CLK = 7'h10;

  always #10 clk_sys = ~clk_sys;

  gtu_top u_gtu_top (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pins(timer_pins),
    .core_toggle_latch(core_toggle_latch), .irq(irq));

  gtu_pin_model u_gtu_pin_model (
    .clk_sys(clk_sys), .in_lvl(in_lvl), .dir_lvl(dir_lvl), .quad_en(quad_en),
    .quad_step(quad_step), .quad_back(quad_back), .timer_pins(timer_pins));

  // ==========================================================================
  // Expectations and checks
  // ==========================================================================
  // Readback keeps only the implemented field width
  function automatic logic [31:0] rb_exp(input logic [7:0] a, input logic [31:0] d);
    case (a)
      gtu_pkg::OFS_CORE_CTRL, gtu_pkg::OFS_AUXA_CTRL, gtu_pkg::OFS_AUXB_CTRL: rb_exp = d & 32'h3ff;
      gtu_pkg::OFS_CORE_CNT, gtu_pkg::OFS_AUXA_CNT, gtu_pkg::OFS_AUXB_CNT: rb_exp = d & 32'hffff;
      gtu_pkg::OFS_IRQ_MASK, gtu_pkg::OFS_PRESCALE: rb_exp = d & 32'h7;
      default: rb_exp = 32'h0;  // Unmapped reads as zero
    endcase
  endfunction

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [6:0] f);
    ctl = {22'h0, f, m};
  endfunction

  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  // Outputs are looked at mid-cycle, away from the edge that moves them
  task automatic chk_out(input logic is_latch, input logic exp);
    @(negedge clk_sys);
    compares++;
    if ((is_latch ? core_toggle_latch : irq) !== exp) begin
      failures++;
      $display("unexpected at %0t: output level wrong", $time);
    end
    @(posedge clk_sys);
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: value %h outside %h..%h", $time, got, lo, hi);
    end
  endtask

  // ==========================================================================
  // Bus and pin tasks
  // ==========================================================================
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // A gap cycle after each strobe keeps every signal to one change per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk_reg(d, e);
  endtask

  // Pulses of four cycles, well above the two-cycle sampling limit
  task automatic pulse(input int g);
    in_lvl[g] <= 1'b1;
    idle(4);
    in_lvl[g] <= 1'b0;
    idle(4);
  endtask

  // Count change between two reads exactly n cycles apart
  task automatic span(input logic [7:0] a, input int n, output logic [31:0] d);
    logic [31:0] x0, x1;
    rd(a, x0);
    idle(n - 2);
    rd(a, x1);
    d = {16'h0, x1[15:0] - x0[15:0]};
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    v0 = $urandom(32'h72c1f68a);
    idle(16);
    nrst <= 1'b1;
    idle(3);
    // Reset values, then random writes including the unmapped hole
    for (int a = 0; a < 10; a++) begin
      rdc(8'(4 * a), 32'h0);
    end
    for (int i = 0; i < 12; i++) begin
      ra = (i % 10 == 6) ? 8'h24 : 8'(4 * (i % 10));
      v0 = $urandom() & ~32'h8;  // Run stays off so counts hold
      wr(ra, v0);
      rdc(ra, rb_exp(ra, v0));
    end
    for (int a = 0; a < 3; a++) begin
      wr(8'(4 * a), 32'h0);
    end
    wr(gtu_pkg::OFS_IRQ_MASK, 32'h0);
    // Rate and direction: software up, software down, pin inverts
    for (int p = 0; p < 3; p++) begin
      for (int dm = 0; dm < 3; dm++) begin
        k = 3 + $urandom_range(2);
        dir_lvl[0] <= (dm == 2);
        wr(gtu_pkg::OFS_PRESCALE, 32'(p));
        wr(gtu_pkg::OFS_CORE_CTRL, ctl(gtu_pkg::GTU_MODE_TIMER,
           RUN | (dm == 1 ? DN : 7'h0) | (dm == 2 ? EXD : 7'h0)));
        idle(4);
        span(gtu_pkg::OFS_CORE_CNT, k * (8 << p), v1);
        chk_reg(v1, {16'h0, dm == 0 ? 16'(k) : 16'(-k)});
      end
    end
    wr(gtu_pkg::OFS_CORE_CTRL, 32'h0);
    dir_lvl[0] <= 1'b0;
    wr(gtu_pkg::OFS_PRESCALE, 32'h0);
    // Gated timer: closed gate holds, open gate counts one per 8 clocks
    wr(gtu_pkg::OFS_AUXA_CTRL, ctl(gtu_pkg::GTU_MODE_GATED, RUN | POL));
    span(gtu_pkg::OFS_AUXA_CNT, 32, v1);
    chk_reg(v1, 32'h0);
    in_lvl[1] <= 1'b1;
    idle(8);
    span(gtu_pkg::OFS_AUXA_CNT, 32, v1);
    chk_reg(v1, 32'h4);
    in_lvl[1] <= 1'b0;
    wr(gtu_pkg::OFS_AUXA_CTRL, 32'h0);
    // Event counter on falling then rising edges
    for (int pol = 0; pol < 2; pol++) begin
      wr(gtu_pkg::OFS_AUXB_CTRL, ctl(gtu_pkg::GTU_MODE_COUNTER, RUN | (pol ? POL : 7'h0)));
      wr(gtu_pkg::OFS_AUXB_CNT, 32'h0);
      repeat (5) pulse(2);
      idle(4);
      rdc(gtu_pkg::OFS_AUXB_CNT, 32'h5);
    end
    wr(gtu_pkg::OFS_AUXB_CTRL, 32'h0);
    // Quadrature: eight edges forward, three back
    wr(gtu_pkg::OFS_CORE_CTRL, ctl(gtu_pkg::GTU_MODE_INCR, RUN));
    wr(gtu_pkg::OFS_CORE_CNT, 32'h10);
    quad_en <= 1'b1;
    idle(2);
    for (int s = 0; s < 11; s++) begin
      quad_back <= (s >= 8);
      quad_step <= 1'b1;
      @(posedge clk_sys);
      quad_step <= 1'b0;
      idle(5);
      if (s == 7) begin
        rdc(gtu_pkg::OFS_CORE_CNT, 32'h18);
      end
    end
    rdc(gtu_pkg::OFS_CORE_CNT, 32'h15);
    wr(gtu_pkg::OFS_CORE_CTRL, 32'h0);
    quad_en <= 1'b0;
    // Capture, then reload from the pin; aux stays frozen while running
    wr(gtu_pkg::OFS_IRQ_STAT, 32'h7);
    wr(gtu_pkg::OFS_CORE_CNT, 32'h0abc);
    wr(gtu_pkg::OFS_AUXA_CTRL, ctl(gtu_pkg::GTU_MODE_CAPTURE, RUN | POL));
    wr(gtu_pkg::OFS_AUXA_CNT, 32'h5555);
    pulse(1);
    idle(4);
    rdc(gtu_pkg::OFS_AUXA_CNT, 32'h0abc);
    idle(40);
    rdc(gtu_pkg::OFS_AUXA_CNT, 32'h0abc);
    wr(gtu_pkg::OFS_AUXB_CTRL, ctl(gtu_pkg::GTU_MODE_RELOAD, POL));
    wr(gtu_pkg::OFS_AUXB_CNT, 32'h1234);
    pulse(2);
    idle(4);
    rdc(gtu_pkg::OFS_CORE_CNT, 32'h1234);
    rdc(gtu_pkg::OFS_IRQ_STAT, 32'h6);
    // Interrupt follows only unmasked flags
    chk_out(1'b0, 1'b0);
    wr(gtu_pkg::OFS_IRQ_MASK, 32'h4);
    chk_out(1'b0, 1'b1);
    wr(gtu_pkg::OFS_IRQ_STAT, 32'h4);
    chk_out(1'b0, 1'b0);
    wr(gtu_pkg::OFS_IRQ_STAT, 32'h7);
    // Latch chain: wrap toggles latch, aux A counts it, aux B reloads per trigger
    wr(gtu_pkg::OFS_AUXA_CTRL, ctl(gtu_pkg::GTU_MODE_TIMER, RUN | CLK));
    wr(gtu_pkg::OFS_AUXA_CNT, 32'h0);
    wr(gtu_pkg::OFS_AUXB_CNT, 32'h100);
    for (int t = 1; t < 4; t++) begin
      wr(gtu_pkg::OFS_AUXB_CTRL, ctl(gtu_pkg::GTU_MODE_RELOAD, {t[1:0], 5'h0}));
      l0  = core_toggle_latch;
      hit = (t == 3) || (t == 1 && !l0) || (t == 2 && l0);
      wr(gtu_pkg::OFS_CORE_CNT, 32'hffff);
      wr(gtu_pkg::OFS_CORE_CTRL, ctl(gtu_pkg::GTU_MODE_TIMER, RUN));
      idle(24);
      wr(gtu_pkg::OFS_CORE_CTRL, 32'h0);
      chk_out(1'b1, !l0);
      rd(gtu_pkg::OFS_CORE_CNT, v1);
      chk_rng(v1, hit ? 32'h100 : 32'h0, hit ? 32'h106 : 32'h6);
      rdc(gtu_pkg::OFS_AUXA_CNT, 32'(t));
      rdc(gtu_pkg::OFS_IRQ_STAT, hit ? 32'h5 : 32'h1);
      wr(gtu_pkg::OFS_IRQ_STAT, 32'h7);
    end
    end_of_test();
  end

  // Whole sequence needs under two thousand cycles; this cuts a hang short
  initial begin
    idle(20000);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
